// File: rtl/texture_mode_control.sv
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

module texture_mode_control (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic reset,
   // Register port.
   input wire logic [texture_mode_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [texture_mode_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [texture_mode_pkg::DATA_W-1:0] reg_rdata,
   // Iterated pixel from the rasterizer.
   input wire texture_mode_pkg::pixel_in_type pixel_in,
   // Texel request and answer from texture memory.
   output texture_mode_pkg::texel_request_type texel_request,
   input wire texture_mode_pkg::texel_in_type [3:0] texel_in,
   // Texel download into texture memory.
   input wire logic download_valid,
   input wire logic [texture_mode_pkg::DL_ADDR_W-1:0] download_addr,
   input wire logic [31:0] download_data,
   output texture_mode_pkg::mem_write_type mem_write,
   // Combined texture colour.
   output texture_mode_pkg::pixel_out_type pixel_out
);
   import texture_mode_pkg::*;

   logic [DATA_W-1:0] mode_r;
   logic [DATA_W-1:0] size_r;
   logic [CNT_W-1:0] pixel_count_r;
   logic [1:0] dither_phase_r;

   // Per-pixel side information; the mode word travels with the pixel so that a
   // register write never changes a pixel already in flight.
   logic stage1_valid_r;
   logic stage2_valid_r;
   logic [DATA_W-1:0] stage1_mode_r;
   logic [DATA_W-1:0] stage2_mode_r;
   logic [WEIGHT_W-1:0] stage1_fs_r;
   logic [WEIGHT_W-1:0] stage1_ft_r;
   logic [WEIGHT_W-1:0] stage2_fs_r;
   logic [WEIGHT_W-1:0] stage2_ft_r;
   logic stage1_bilinear_r;
   logic stage2_bilinear_r;
   logic [LOD_W-1:0] stage1_lod_r;
   logic [LOD_W-1:0] stage2_lod_r;
   logic [31:0] stage1_other_r;
   logic [31:0] stage2_other_r;

   // Wrap or clamp one integer coordinate into a power-of-two texture size.
   function automatic logic [IDX_W-1:0] fit_coord(input logic signed [INT_W-1:0] c,
                                                  input logic clamp,
                                                  input logic [SZ_LOG_W-1:0] size_log);
      logic [INT_W-1:0] limit;
      logic [INT_W-1:0] fitted;
      limit = INT_W'((INT_W'(1) << size_log) - INT_W'(1));
      if (clamp) begin
         if (c < 0) begin
            fitted = '0;
         end else if (INT_W'(c) > limit) begin
            fitted = limit;
         end else begin
            fitted = INT_W'(c);
         end
      end else begin
         fitted = INT_W'(c) & limit;
      end
      return fitted[IDX_W-1:0];
   endfunction

   // Expand one texel into 32-bit ARGB.
   function automatic logic [31:0] expand_texel(input logic [FMT_W-1:0] fmt,
                                                input texel_in_type tx);
      logic [TEXEL_W-1:0] d;
      logic [7:0] pr;
      logic [7:0] pg;
      logic [7:0] pb;
      logic [31:0] argb;
      d = tx.data;
      pr = tx.palette_rgb[23:16];
      pg = tx.palette_rgb[15:8];
      pb = tx.palette_rgb[7:0];
      unique case (format_type'(fmt))
         FMT_RGB332: argb = {ALPHA_OPAQUE, d[7:5], d[7:5], d[7:6], d[4:2], d[4:2],
                             d[4:3], {4{d[1:0]}}};
         FMT_YIQ422: argb = {ALPHA_OPAQUE, tx.ncc_rgb};
         FMT_ALPHA8: argb = {4{d[7:0]}};
         FMT_INT8: argb = {ALPHA_OPAQUE, {3{d[7:0]}}};
         FMT_AI44: argb = {{2{d[7:4]}}, {6{d[3:0]}}};
         FMT_PAL8: argb = {ALPHA_OPAQUE, tx.palette_rgb};
         FMT_PAL6666: argb = {pr[7:2], pr[7:6], pr[1:0], pg[7:4], pr[1:0],
                              pg[3:0], pb[7:6], pg[3:2], pb[5:0], pb[5:4]};
         FMT_ARGB8332: argb = {d[15:8], d[7:5], d[7:5], d[7:6], d[4:2], d[4:2],
                               d[4:3], {4{d[1:0]}}};
         FMT_AYIQ8422: argb = {d[15:8], tx.ncc_rgb};
         FMT_RGB565: argb = {ALPHA_OPAQUE, d[15:11], d[15:13], d[10:5], d[10:9],
                             d[4:0], d[4:2]};
         FMT_ARGB1555: argb = {{8{d[15]}}, d[14:10], d[14:12], d[9:5], d[9:7],
                               d[4:0], d[4:2]};
         FMT_ARGB4444: argb = {{2{d[15:12]}}, {2{d[11:8]}}, {2{d[7:4]}},
                               {2{d[3:0]}}};
         FMT_AI88: argb = {d[15:8], {3{d[7:0]}}};
         FMT_AP88: argb = {d[15:8], tx.palette_rgb};
         FMT_RSVD7, FMT_RSVD15: argb = '0;
      endcase
      return argb;
   endfunction

   // Weighted blend of four 8-bit samples; the weights sum to 256 so the
   // result never exceeds 255.
   function automatic logic [7:0] blend4(input logic [7:0] c00, input logic [7:0] c10,
                                         input logic [7:0] c01, input logic [7:0] c11,
                                         input logic [WEIGHT_W-1:0] fs,
                                         input logic [WEIGHT_W-1:0] ft);
      logic [WEIGHT_W:0] is;
      logic [WEIGHT_W:0] it;
      logic [19:0] sum;
      is = (WEIGHT_W+1)'(5'h10 - {1'b0, fs});
      it = (WEIGHT_W+1)'(5'h10 - {1'b0, ft});
      sum = 20'(c00) * 20'(is) * 20'(it) + 20'(c10) * 20'(fs) * 20'(it)
          + 20'(c01) * 20'(is) * 20'(ft) + 20'(c11) * 20'(fs) * 20'(ft);
      return sum[15:8];
   endfunction

   // One combine datapath, shared by the three colour channels and alpha.
   function automatic logic [7:0] combine(input logic [CTRL_W-1:0] ctrl,
                                          input logic [7:0] c_local,
                                          input logic [7:0] a_local,
                                          input logic [7:0] c_other,
                                          input logic [7:0] a_other,
                                          input logic [LOD_W-1:0] lod);
      logic signed [9:0] diff;
      logic [7:0] factor;
      logic signed [19:0] product;
      logic signed [19:0] total;
      logic [7:0] result;
      diff = (ctrl[CB_ZERO_OTHER] ? 10'sh000 : signed'({2'b00, c_other}))
           - (ctrl[CB_SUB_LOCAL] ? signed'({2'b00, c_local}) : 10'sh000);
      unique case (mselect_type'(ctrl[CB_MSEL_LSB +: CB_MSEL_W]))
         MSEL_ZERO: factor = 8'h00;
         MSEL_LOCAL: factor = c_local;
         MSEL_OTHER_ALPHA: factor = a_other;
         MSEL_LOCAL_ALPHA: factor = a_local;
         MSEL_LOD: factor = {lod, 2'b00};
         MSEL_LOD_FRAC: factor = {lod[1:0], 6'h00};
         MSEL_RSVD6, MSEL_RSVD7: factor = 8'h00;
      endcase
      if (ctrl[CB_REVERSE]) begin
         factor = ~factor;
      end
      product = (20'(diff) * 20'(signed'({2'b00, factor} + 10'h001))) >>> 8;
      total = product;
      if (ctrl[CB_ADD_COLOR]) begin
         total = total + signed'({12'h000, c_local});
      end else if (ctrl[CB_ADD_ALPHA]) begin
         total = total + signed'({12'h000, a_local});
      end
      if (total < 0) begin
         result = 8'h00;
      end else if (total > 20'sh000ff) begin
         result = 8'hff;
      end else begin
         result = total[7:0];
      end
      return ctrl[CB_INVERT] ? ~result : result;
   endfunction

   // Register writes.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         mode_r <= MODE_RESET;
         size_r <= SIZE_RESET;
      end else if (reg_write) begin
         if (reg_addr == MODE_OFFSET) begin
            mode_r <= reg_wdata;
         end
         if (reg_addr == SIZE_OFFSET) begin
            size_r <= {{(DATA_W-SZ_USED_W){1'b0}}, reg_wdata[SZ_USED_W-1:0]};
         end
      end
   end

   // Register reads answer in the following cycle only; unmapped words read zero.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         reg_rdata <= '0;
      end else if (reg_read) begin
         unique case (reg_addr)
            MODE_OFFSET: reg_rdata <= mode_r;
            SIZE_OFFSET: reg_rdata <= size_r;
            STATUS_OFFSET: reg_rdata <= {13'h0000, pixel_out.valid, stage2_valid_r,
                                         stage1_valid_r, pixel_count_r};
            default: reg_rdata <= '0;
         endcase
      end else begin
         reg_rdata <= '0;
      end
   end

   // Coordinate stage: perspective, negative-W clamp, LOD and filter choice.
   logic signed [W_W-1:0] w_eff;
   logic signed [COORD_W+W_W-1:0] s_prod;
   logic signed [COORD_W+W_W-1:0] t_prod;
   logic signed [COORD_W-1:0] s_coord;
   logic signed [COORD_W-1:0] t_coord;
   logic signed [INT_W-1:0] s_int;
   logic signed [INT_W-1:0] t_int;
   logic [LOD_W:0] lod_sum;
   logic [LOD_W-1:0] lod_dithered;
   logic minify;
   logic bilinear;

   always_comb begin
      // A single multiplier per axis keeps one pixel per clock either way.
      w_eff = mode_r[PERSP_BIT] ? pixel_in.w : W_ONE;
      s_prod = pixel_in.s_over_w * w_eff;
      t_prod = pixel_in.t_over_w * w_eff;
      s_coord = s_prod[W_FRAC +: COORD_W];
      t_coord = t_prod[W_FRAC +: COORD_W];
      if (mode_r[CLAMPW_BIT] && w_eff < 0) begin
         s_coord = '0;
         t_coord = '0;
      end
      s_int = s_coord[FRAC_W +: INT_W];
      t_int = t_coord[FRAC_W +: INT_W];
      // The phase walks 0..3 quarter steps, an average of 3/8 of a level.
      lod_sum = {1'b0, pixel_in.lod}
              + (mode_r[DITHER_BIT] ? (LOD_W+1)'(dither_phase_r) : '0);
      lod_dithered = lod_sum[LOD_W] ? LOD_MAX : lod_sum[LOD_W-1:0];
      minify = lod_dithered >= size_r[SZ_LODMIN_LSB +: LOD_W];
      bilinear = minify ? mode_r[MINFILT_BIT] : mode_r[MAGFILT_BIT];
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         texel_request <= '0;
      end else begin
         texel_request.valid <= pixel_in.valid;
         texel_request.s0 <= fit_coord(s_int, mode_r[CLAMPS_BIT],
                                       size_r[SZ_WIDTH_LSB +: SZ_LOG_W]);
         texel_request.t0 <= fit_coord(t_int, mode_r[CLAMPT_BIT],
                                       size_r[SZ_HEIGHT_LSB +: SZ_LOG_W]);
         // Point sampling reads only the addressed texel.
         texel_request.s1 <= fit_coord(bilinear ? INT_W'(s_int + 1) : s_int,
                                       mode_r[CLAMPS_BIT],
                                       size_r[SZ_WIDTH_LSB +: SZ_LOG_W]);
         texel_request.t1 <= fit_coord(bilinear ? INT_W'(t_int + 1) : t_int,
                                       mode_r[CLAMPT_BIT],
                                       size_r[SZ_HEIGHT_LSB +: SZ_LOG_W]);
         texel_request.bilinear <= bilinear;
         texel_request.trilinear <= mode_r[TRILINEAR_BIT];
         texel_request.ncc_table <= mode_r[NCCSEL_BIT];
         texel_request.lod <= lod_dithered;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         dither_phase_r <= '0;
         pixel_count_r <= '0;
      end else if (pixel_in.valid) begin
         dither_phase_r <= dither_phase_r + 2'h1;
         pixel_count_r <= pixel_count_r + CNT_W'(1);
      end
   end

   // Side information waits alongside the texel fetch, which answers one
   // cycle after the request.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         stage1_valid_r <= 1'b0;
         stage2_valid_r <= 1'b0;
         stage1_mode_r <= MODE_RESET;
         stage2_mode_r <= MODE_RESET;
         stage1_fs_r <= '0;
         stage1_ft_r <= '0;
         stage2_fs_r <= '0;
         stage2_ft_r <= '0;
         stage1_bilinear_r <= 1'b0;
         stage2_bilinear_r <= 1'b0;
         stage1_lod_r <= '0;
         stage2_lod_r <= '0;
         stage1_other_r <= '0;
         stage2_other_r <= '0;
      end else begin
         stage1_valid_r <= pixel_in.valid;
         stage1_mode_r <= mode_r;
         stage1_fs_r <= s_coord[FRAC_W-1 -: WEIGHT_W];
         stage1_ft_r <= t_coord[FRAC_W-1 -: WEIGHT_W];
         stage1_bilinear_r <= bilinear;
         stage1_lod_r <= lod_dithered;
         stage1_other_r <= pixel_in.other_argb;
         stage2_valid_r <= stage1_valid_r;
         stage2_mode_r <= stage1_mode_r;
         stage2_fs_r <= stage1_fs_r;
         stage2_ft_r <= stage1_ft_r;
         stage2_bilinear_r <= stage1_bilinear_r;
         stage2_lod_r <= stage1_lod_r;
         stage2_other_r <= stage1_other_r;
      end
   end

   // Filter and combine stage.
   logic [31:0] tex_argb [4];
   logic [31:0] filtered;
   logic [31:0] combined;

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         tex_argb[i] = expand_texel(stage2_mode_r[FMT_LSB +: FMT_W], texel_in[i]);
      end
      for (int ch = 0; ch < 4; ch++) begin
         if (stage2_bilinear_r) begin
            filtered[ch*8 +: 8] = blend4(tex_argb[0][ch*8 +: 8], tex_argb[1][ch*8 +: 8],
                                         tex_argb[2][ch*8 +: 8], tex_argb[3][ch*8 +: 8],
                                         stage2_fs_r, stage2_ft_r);
         end else begin
            filtered[ch*8 +: 8] = tex_argb[0][ch*8 +: 8];
         end
      end
      for (int ch = 0; ch < 3; ch++) begin
         combined[ch*8 +: 8] = combine(stage2_mode_r[CC_LSB +: CTRL_W], filtered[ch*8 +: 8],
                                       filtered[31:24], stage2_other_r[ch*8 +: 8],
                                       stage2_other_r[31:24], stage2_lod_r);
      end
      combined[31:24] = combine(stage2_mode_r[CA_LSB +: CTRL_W], filtered[31:24],
                                filtered[31:24], stage2_other_r[31:24],
                                stage2_other_r[31:24], stage2_lod_r);
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         pixel_out <= '0;
      end else begin
         pixel_out.valid <= stage2_valid_r;
         pixel_out.argb <= stage2_valid_r ? combined : '0;
      end
   end

   // Texel downloads: narrow formats land on even words unless sequential.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         mem_write <= '0;
      end else begin
         mem_write.valid <= download_valid;
         mem_write.data <= download_data;
         if (!mode_r[FMT_LSB + FMT_W - 1] && !mode_r[SEQ8_BIT]) begin
            mem_write.addr <= {download_addr, 1'b0};
         end else begin
            mem_write.addr <= {1'b0, download_addr};
         end
      end
   end

endmodule // texture_mode_control

`default_nettype wire

// File: rtl/texture_mode_pkg.sv
package texture_mode_pkg;

   // Register port geometry and word indices.
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam logic [ADDR_W-1:0] MODE_OFFSET = 4'h0;
   localparam logic [ADDR_W-1:0] SIZE_OFFSET = 4'h1;
   localparam logic [ADDR_W-1:0] STATUS_OFFSET = 4'h2;
   localparam logic [DATA_W-1:0] MODE_RESET = 32'h0000_0000;
   localparam logic [DATA_W-1:0] SIZE_RESET = 32'h0000_0000;

   // Field positions of texture_mapping_control.
   localparam int PERSP_BIT = 0;
   localparam int MINFILT_BIT = 1;
   localparam int MAGFILT_BIT = 2;
   localparam int CLAMPW_BIT = 3;
   localparam int DITHER_BIT = 4;
   localparam int NCCSEL_BIT = 5;
   localparam int CLAMPS_BIT = 6;
   localparam int CLAMPT_BIT = 7;
   localparam int FMT_LSB = 8;
   localparam int FMT_W = 4;
   localparam int CC_LSB = 12;
   localparam int CA_LSB = 21;
   localparam int CTRL_W = 9;
   localparam int TRILINEAR_BIT = 30;
   localparam int SEQ8_BIT = 31;

   // Bit positions inside one nine-bit combine control field.
   localparam int CB_ZERO_OTHER = 0;
   localparam int CB_SUB_LOCAL = 1;
   localparam int CB_MSEL_LSB = 2;
   localparam int CB_MSEL_W = 3;
   localparam int CB_REVERSE = 5;
   localparam int CB_ADD_COLOR = 6;
   localparam int CB_ADD_ALPHA = 7;
   localparam int CB_INVERT = 8;

   // Fields of the size register.
   localparam int SZ_WIDTH_LSB = 0;
   localparam int SZ_HEIGHT_LSB = 4;
   localparam int SZ_LOG_W = 4;
   localparam int SZ_LODMIN_LSB = 8;
   localparam int SZ_USED_W = 14;

   // Number formats of the datapath.
   localparam int COORD_W = 20;
   localparam int FRAC_W = 8;
   localparam int INT_W = COORD_W - FRAC_W;
   localparam int WEIGHT_W = 4;
   localparam int W_W = 16;
   localparam int W_FRAC = 8;
   localparam logic signed [W_W-1:0] W_ONE = 16'sh0100;
   localparam int LOD_W = 6;
   localparam logic [LOD_W-1:0] LOD_MAX = 6'h3f;
   localparam int IDX_W = 8;
   localparam int TEXEL_W = 16;
   localparam int RGB_W = 24;
   localparam int DL_ADDR_W = 20;
   localparam int CNT_W = 16;
   localparam logic [7:0] ALPHA_OPAQUE = 8'hff;

   typedef enum logic [FMT_W-1:0] {
      FMT_RGB332 = 4'h0, FMT_YIQ422 = 4'h1, FMT_ALPHA8 = 4'h2, FMT_INT8 = 4'h3,
      FMT_AI44 = 4'h4, FMT_PAL8 = 4'h5, FMT_PAL6666 = 4'h6, FMT_RSVD7 = 4'h7,
      FMT_ARGB8332 = 4'h8, FMT_AYIQ8422 = 4'h9, FMT_RGB565 = 4'ha, FMT_ARGB1555 = 4'hb,
      FMT_ARGB4444 = 4'hc, FMT_AI88 = 4'hd, FMT_AP88 = 4'he, FMT_RSVD15 = 4'hf
   } format_type;

   typedef enum logic [CB_MSEL_W-1:0] {
      MSEL_ZERO = 3'h0, MSEL_LOCAL = 3'h1, MSEL_OTHER_ALPHA = 3'h2,
      MSEL_LOCAL_ALPHA = 3'h3, MSEL_LOD = 3'h4, MSEL_LOD_FRAC = 3'h5,
      MSEL_RSVD6 = 3'h6, MSEL_RSVD7 = 3'h7
   } mselect_type;

   typedef struct packed {
      logic valid;
      logic signed [COORD_W-1:0] s_over_w;
      logic signed [COORD_W-1:0] t_over_w;
      logic signed [W_W-1:0] w;
      logic [LOD_W-1:0] lod;
      logic [31:0] other_argb;
   } pixel_in_type;

   typedef struct packed {
      logic valid;
      logic [IDX_W-1:0] s0;
      logic [IDX_W-1:0] s1;
      logic [IDX_W-1:0] t0;
      logic [IDX_W-1:0] t1;
      logic bilinear;
      logic trilinear;
      logic ncc_table;
      logic [LOD_W-1:0] lod;
   } texel_request_type;

   typedef struct packed {
      logic [TEXEL_W-1:0] data;
      logic [RGB_W-1:0] ncc_rgb;
      logic [RGB_W-1:0] palette_rgb;
   } texel_in_type;

   typedef struct packed {
      logic valid;
      logic [DL_ADDR_W:0] addr;
      logic [31:0] data;
   } mem_write_type;

   typedef struct packed {
      logic valid;
      logic [31:0] argb;
   } pixel_out_type;

endpackage

// File: verification/texture_mode_control_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module texture_mode_control_assertions (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic reset,
   // Register port.
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   // Pixel path.
   input wire texture_mode_pkg::pixel_in_type pixel_in,
   input wire texture_mode_pkg::texel_request_type texel_request,
   input wire texture_mode_pkg::pixel_out_type pixel_out,
   // Download path.
   input wire logic download_valid,
   input wire logic [19:0] download_addr,
   input wire logic [31:0] download_data,
   input wire texture_mode_pkg::mem_write_type mem_write
);
   import texture_mode_pkg::*;
   logic [31:0] mode_r;
   logic [5:0] lodmin_r;
   // Shadows of the registers, updated on the same edge as the design's own copies.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         mode_r <= MODE_RESET;
         lodmin_r <= 6'h00;
      end else if (reg_write) begin
         if (reg_addr == MODE_OFFSET) begin
            mode_r <= reg_wdata;
         end
         if (reg_addr == SIZE_OFFSET) begin
            lodmin_r <= reg_wdata[13:8];
         end
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   AST_REQ_LAT: assert property (pixel_in.valid |=> texel_request.valid)
      else $error("no texel request after pixel");
   AST_OUT_LAT: assert property (pixel_in.valid |-> ##3 pixel_out.valid)
      else $error("no pixel out three cycles after pixel");
   AST_NCC: assert property (
      texel_request.valid |-> texel_request.ncc_table == $past(mode_r[5]))
      else $error("table select not passed on");
   AST_TRI: assert property (
      texel_request.valid |-> texel_request.trilinear == $past(mode_r[30]))
      else $error("trilinear flag not passed on");
   AST_CLAMPW: assert property (
      texel_request.valid && $past(mode_r[3]) && $past(mode_r[0]) && $past(pixel_in.w[15])
      |-> texel_request.s0 == 8'h00 && texel_request.t0 == 8'h00)
      else $error("negative w did not zero s and t");
   AST_FILTER: assert property (
      texel_request.valid && !$past(mode_r[4]) |-> texel_request.bilinear ==
      (($past(pixel_in.lod) >= $past(lodmin_r)) ? $past(mode_r[1]) : $past(mode_r[2])))
      else $error("wrong filter chosen");
   AST_LOD: assert property (
      texel_request.valid && !$past(mode_r[4]) |-> texel_request.lod == $past(pixel_in.lod))
      else $error("lod changed without dither");
   AST_DL: assert property (
      download_valid |=> mem_write.valid && mem_write.data == $past(download_data) &&
      mem_write.addr == (($past(mode_r[11]) || $past(mode_r[31])) ?
      {1'b0, $past(download_addr)} : {$past(download_addr), 1'b0}))
      else $error("wrong download write");
   AST_RSVD: assert property (
      pixel_out.valid && $past(mode_r[10:8], 3) == 3'h7 |-> pixel_out.argb == 32'h0000_0000)
      else $error("reserved format gave colour");
endmodule // texture_mode_control_assertions
`default_nettype wire

// File: verification/texture_memory_model.sv
`timescale 1ns/1ns
`default_nettype none
module texture_memory_model (
   // Clock.
   input wire logic ref_clk,
   // Request and the stored texel to return.
   input wire texture_mode_pkg::texel_request_type texel_request,
   input wire texture_mode_pkg::texel_in_type content,
   // Answer.
   output texture_mode_pkg::texel_in_type [3:0] texel_in
);
   import texture_mode_pkg::*;
   // Outside the answer cycle the bus shows the inverse, so a late sample cannot match.
   always_ff @(posedge ref_clk) begin
      for (int i = 0; i < 4; i++) begin
         texel_in[i] <= texel_request.valid ? content : ~content;
      end
   end
endmodule // texture_memory_model
`default_nettype wire

// File: verification/texture_mode_control_tb.sv
`timescale 1ns/1ns
`default_nettype none
module texture_mode_control_tb;
   import texture_mode_pkg::*;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [31:0] reg_rdata;
   pixel_in_type pixel_in = '0;
   texel_request_type texel_request;
   texel_in_type [3:0] texel_in;
   texel_in_type content = '{16'h0, 24'h123456, 24'habcdef};
   logic download_valid = 1'b0;
   logic [19:0] download_addr = 20'h0;
   logic [31:0] download_data = 32'h0;
   mem_write_type mem_write;
   pixel_out_type pixel_out;
   int n_mismatch = 0;
   int tests_run = 0;
   localparam logic [8:0] PASS = 9'h041;
   localparam logic [8:0] INV = 9'h141;
   // Format, stored texel, expected colour with the combine passing the texel through.
   localparam logic [51:0] ROWS [16] = '{
      {4'h0, 16'hb6b6, 32'hffb6b6aa}, {4'h1, 16'h0000, 32'hff123456},
      {4'h2, 16'h5a5a, 32'h5a5a5a5a}, {4'h3, 16'h3c3c, 32'hff3c3c3c},
      {4'h4, 16'h7e7e, 32'h77eeeeee}, {4'h5, 16'h0000, 32'hffabcdef},
      {4'h6, 16'h0000, 32'haaf3dfbe}, {4'h7, 16'hffff, 32'h00000000},
      {4'h8, 16'h40e3, 32'h40ff00ff}, {4'h9, 16'h6600, 32'h66123456},
      {4'ha, 16'hf81f, 32'hffff00ff}, {4'hb, 16'h8000, 32'hff000000},
      {4'hc, 16'h1234, 32'h11223344}, {4'hd, 16'h80c3, 32'h80c3c3c3},
      {4'he, 16'h7700, 32'h77abcdef}, {4'hf, 16'hffff, 32'h00000000}};
   texture_mode_control i_texture_mode_control (
      .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .pixel_in(pixel_in), .texel_request(texel_request), .texel_in(texel_in),
      .download_valid(download_valid), .download_addr(download_addr),
      .download_data(download_data), .mem_write(mem_write), .pixel_out(pixel_out));
   texture_memory_model i_texture_memory_model (
      .ref_clk(ref_clk), .texel_request(texel_request), .content(content),
      .texel_in(texel_in));
   always #10 ref_clk = ~ref_clk;
   task automatic stop_test();
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(input logic [63:0] g, input logic [63:0] e);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge ref_clk);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge ref_clk);
      reg_read <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask
   function automatic logic [31:0] md(input logic [3:0] f, input logic [8:0] cc,
                                      input logic [7:0] low, input logic [1:0] top);
      return {top, cc, cc, f, low};
   endfunction
   // Expected request: trilinear, table, bilinear, s0, t0.
   task automatic pix(input logic [15:0] w, input logic [5:0] lod,
                      input logic [18:0] e_req, input logic [31:0] e_out);
      @(posedge ref_clk);
      pixel_in <= '{1'b1, 20'h00a00, 20'h00a00, w, lod, 32'h0};
      @(posedge ref_clk);
      pixel_in.valid <= 1'b0;
      #1 chk({texel_request.valid, texel_request.trilinear, texel_request.ncc_table,
              texel_request.bilinear, texel_request.s0, texel_request.t0}, {1'b1, e_req});
      repeat (2) @(posedge ref_clk);
      #1 chk({pixel_out.valid, pixel_out.argb}, {1'b1, e_out});
   endtask
   task automatic dl(input logic [19:0] a, input logic [20:0] e);
      @(posedge ref_clk);
      download_valid <= 1'b1;
      download_addr <= a;
      download_data <= {12'h0a5, a};
      @(posedge ref_clk);
      download_valid <= 1'b0;
      #1 chk({mem_write.valid, mem_write.addr, mem_write.data}, {1'b1, e, 12'h0a5, a});
   endtask
   initial begin
      repeat (5000) @(posedge ref_clk);
      n_mismatch++;
      stop_test();
   end
   initial begin
      repeat (20) @(posedge ref_clk);
      reset <= 1'b0;
      rd(MODE_OFFSET, MODE_RESET);
      wr(SIZE_OFFSET, 32'hffff_ffff);
      rd(SIZE_OFFSET, 32'h0000_3fff);
      rd(4'h9, 32'h0000_0000);
      // Four by four map with a minimum lod of 4.0; ten wraps to two.
      wr(SIZE_OFFSET, 32'h0000_1022);
      foreach (ROWS[i]) begin
         wr(MODE_OFFSET, md(ROWS[i][51:48], PASS, 8'h00, 2'b00));
         content.data <= ROWS[i][47:32];
         pix(16'h0100, 6'h00, 19'h00202, ROWS[i][31:0]);
      end
      wr(MODE_OFFSET, md(4'h3, PASS, 8'hc0, 2'b00));
      content.data <= 16'h3c3c;
      pix(16'h0100, 6'h00, 19'h00303, 32'hff3c3c3c);
      // Minus one for w flips ten to minus ten, which wraps to two unless clamped.
      wr(MODE_OFFSET, md(4'h3, PASS, 8'h01, 2'b00));
      pix(16'hff00, 6'h00, 19'h00202, 32'hff3c3c3c);
      wr(MODE_OFFSET, md(4'h3, PASS, 8'h09, 2'b00));
      pix(16'hff00, 6'h00, 19'h00000, 32'hff3c3c3c);
      wr(MODE_OFFSET, md(4'h3, PASS, 8'h22, 2'b01));
      pix(16'h0100, 6'h10, 19'h70202, 32'hff3c3c3c);
      pix(16'h0100, 6'h0f, 19'h60202, 32'hff3c3c3c);
      wr(MODE_OFFSET, md(4'h3, INV, 8'h00, 2'b00));
      pix(16'h0100, 6'h00, 19'h00202, 32'h00c3c3c3);
      dl(20'h00005, 21'h0000a);
      wr(MODE_OFFSET, md(4'h3, PASS, 8'h00, 2'b10));
      dl(20'h00005, 21'h00005);
      wr(MODE_OFFSET, md(4'ha, PASS, 8'h00, 2'b00));
      dl(20'h00005, 21'h00005);
      // Twenty-two pixels went through and the pipe has drained.
      rd(STATUS_OFFSET, 32'h0000_0016);
      @(posedge ref_clk);
      reset <= 1'b1;
      repeat (2) @(posedge ref_clk);
      reset <= 1'b0;
      rd(MODE_OFFSET, MODE_RESET);
      rd(SIZE_OFFSET, SIZE_RESET);
      stop_test();
   end
endmodule // texture_mode_control_tb
bind texture_mode_control texture_mode_control_assertions i_texture_mode_control_assertions (
   .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_write(reg_write), .pixel_in(pixel_in), .texel_request(texel_request),
   .pixel_out(pixel_out), .download_valid(download_valid), .download_addr(download_addr),
   .download_data(download_data), .mem_write(mem_write));
`default_nettype wire
